// ==== hup_core.sv ====
// Purpose: Host pins, modem lines, baud clock and a simple serial path
// Assumes: All inputs synchronous to clk; strobes sampled each enabled cycle
// Notes:   Transmit bytes queue in a FIFO ahead of the shifter
`timescale 1ns/1ps

// Overview of operation
// - Read strobe low drives addressed register out
// - Write strobe low stores bus data
// - Interrupt high only for enabled active source
// - Sources: errors, rx data, tx empty, modem
// - Select indicator high while chip selected
// - Baud output is sixteen times data rate
// - Receiver timed by 16x receive clock input
// - Drive disable low during host read
// - User output one follows modem control bit 2
// - User output two follows modem control bit 3
// - Reset returns registers and outputs to defaults
// - Reset holds transmitter and receiver disabled
// - Clear-to-send readable at status bit 4 only
// - Data-set-ready is status only
// - Control bit 0 drives terminal-ready low
// - Control bit 1 drives request-to-send low
// - Selected when a, b high, c low
// - Address strobe fall latches selects, high transparent
// - Divisor bytes at 0,1 when line bit 7 set
module hup_core #(
  parameter int FIFO_DEPTH = 16
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic select_in_a,
  input wire logic select_in_b,
  input wire logic select_in_c_n,
  input wire logic [2:0] reg_sel,
  input wire logic addr_latch_strobe_n,
  input wire logic read_strobe_low,
  input wire logic write_strobe_low,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe_n,
  output logic irq,
  output logic selected_indicator,
  output logic bus_drive_disable_n,
  output logic baud_out_n,
  input wire logic rx_clk_16x,
  input wire logic rx_serial,
  output logic tx_serial,
  output logic user_output_one_n,
  output logic user_output_two_n,
  output logic term_ready_n,
  output logic req_send_n,
  input wire hup_pkg::hup_modem_in_t modem_in
);
  import hup_pkg::*;

  // ----------------------------------------------------------------
  // Address latch and select
  // ----------------------------------------------------------------
  hup_addr_t live_addr;
  hup_addr_t addr_q;
  hup_addr_t acc_addr;
  logic strobe_q;
  logic hold_q;
  logic acc_seen_q;
  logic any_strobe;
  logic sel;
  logic rd_act;
  logic wr_act;
  logic wr_q;

  assign live_addr = '{select_in_a, select_in_b, select_in_c_n, reg_sel};

  // A fall of the strobe holds the selects until that access ends; a strobe
  // tied low never falls, so the selects then pass straight through
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      addr_q <= '0;
      strobe_q <= 1'b0;
      hold_q <= 1'b0;
      acc_seen_q <= 1'b0;
    end
    else if (clk_en)
    begin
      strobe_q <= addr_latch_strobe_n;
      if (!hold_q)
        addr_q <= live_addr;
      if (addr_latch_strobe_n || (acc_seen_q && !any_strobe))
      begin
        hold_q <= 1'b0;
        acc_seen_q <= 1'b0;
      end
      else if (strobe_q)
        hold_q <= 1'b1;
      else if (hold_q && any_strobe)
        acc_seen_q <= 1'b1;
    end
  end

  assign any_strobe = !read_strobe_low || !write_strobe_low;
  // Strobe high is transparent at once
  assign acc_addr = (hold_q && !addr_latch_strobe_n) ? addr_q : live_addr;

  function automatic logic is_sel(input hup_addr_t a);
    is_sel = a.sel_a && a.sel_b && !a.sel_c_n;
  endfunction : is_sel

  assign sel = is_sel(acc_addr);
  assign selected_indicator = sel;
  assign rd_act = sel && !read_strobe_low;
  assign wr_act = sel && !write_strobe_low;
  assign bus_drive_disable_n = !rd_act;
  assign data_oe_n = !rd_act;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] ien_q;
  logic [7:0] lctl_q;
  logic [7:0] mctl_q;
  logic [7:0] scratch_q;
  logic [15:0] div_q;
  logic div_acc;
  logic wr_edge;
  logic [7:0] rx_hold_q;
  logic rx_avail_q;
  logic overrun_q;
  logic msr_delta_q;
  logic tx_push;

  assign div_acc = lctl_q[HUP_LC_DIV_ACCESS];
  // Only the first cycle of a write commits, so a long strobe is one write
  assign wr_edge = wr_act && !wr_q;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      wr_q <= 1'b0;
    else if (clk_en)
      wr_q <= wr_act;
  end

  // Host writes into addressed register
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ien_q <= HUP_RST_BYTE;
      lctl_q <= HUP_RST_BYTE;
      mctl_q <= HUP_RST_BYTE;
      scratch_q <= HUP_RST_BYTE;
      div_q <= HUP_RST_DIV;
    end
    else if (clk_en && wr_edge)
    begin
      if (div_acc && acc_addr.reg_sel == HUP_OFS_DIV_LO)
        div_q[7:0] <= data_in;
      else if (div_acc && acc_addr.reg_sel == HUP_OFS_DIV_HI)
        div_q[15:8] <= data_in;
      else if (acc_addr.reg_sel == HUP_OFS_IEN)
        ien_q <= {4'h0, data_in[3:0]};
      else if (acc_addr.reg_sel == HUP_OFS_LCTL)
        lctl_q <= data_in;
      else if (acc_addr.reg_sel == HUP_OFS_MCTL)
        mctl_q <= {4'h0, data_in[3:0]};
      else if (acc_addr.reg_sel == HUP_OFS_SCRATCH)
        scratch_q <= data_in;
    end
  end

  assign tx_push = wr_edge && !div_acc && acc_addr.reg_sel == HUP_OFS_DATA;

  // ----------------------------------------------------------------
  // Modem lines
  // ----------------------------------------------------------------
  hup_modem_in_t m_s1_q;
  hup_modem_in_t m_s2_q;
  hup_modem_in_t m_old_q;

  // Two-stage synchroniser; the inputs only feed status, never the serial path
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      m_s1_q <= HUP_RST_MODEM_IN;
      m_s2_q <= HUP_RST_MODEM_IN;
      m_old_q <= HUP_RST_MODEM_IN;
    end
    else if (clk_en)
    begin
      m_s1_q <= modem_in;
      m_s2_q <= m_s1_q;
      m_old_q <= m_s2_q;
    end
  end

  logic [7:0] msr_val;
  logic [3:0] m_chg;
  logic msr_rd;
  assign m_chg = m_s2_q ^ m_old_q;
  // Upper nibble shows inverted pin levels: CTS bit4, DSR bit5, ring bit6, carrier bit7
  assign msr_val = {~m_s2_q.carrier_detect_n, ~m_s2_q.ring_n, ~m_s2_q.dsr_n,
                    ~m_s2_q.cts_n, 3'h0, msr_delta_q};
  assign msr_rd = rd_act && acc_addr.reg_sel == HUP_OFS_MSTAT;

  // Change flag; a new change wins over the clearing read
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      msr_delta_q <= 1'b0;
    else if (clk_en)
    begin
      if (m_chg != 4'h0)
        msr_delta_q <= 1'b1;
      else if (msr_rd)
        msr_delta_q <= 1'b0;
    end
  end

  // Modem control outputs, low when bit set; reset gives all high
  assign term_ready_n = !mctl_q[HUP_MC_TERM_RDY];
  assign req_send_n = !mctl_q[HUP_MC_REQ_SEND];
  assign user_output_one_n = !mctl_q[HUP_MC_USER_ONE];
  assign user_output_two_n = !mctl_q[HUP_MC_USER_TWO];

  // ----------------------------------------------------------------
  // Baud generator
  // ----------------------------------------------------------------
  logic [15:0] bcnt_q;
  logic baud_q;

  // Divide clk by divisor; pulse low one cycle per 16x tick
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      bcnt_q <= 16'h0000;
      baud_q <= 1'b1;
    end
    else if (clk_en)
    begin
      if (bcnt_q + 16'h0001 >= div_q)
      begin
        bcnt_q <= 16'h0000;
        baud_q <= 1'b0;
      end
      else
      begin
        bcnt_q <= bcnt_q + 16'h0001;
        baud_q <= 1'b1;
      end
    end
  end
  assign baud_out_n = baud_q;

  // ----------------------------------------------------------------
  // Transmit path with FIFO
  // ----------------------------------------------------------------
  logic [7:0] f_data;
  logic f_valid;
  logic f_ready;
  logic tx_busy_q;
  logic [9:0] tx_sh_q;
  logic [3:0] tx_bits_q;
  logic [3:0] tx_tick_q;
  logic tx_tick;

  hup_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_txf (
    .clk(clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .in_data(data_in),
    .in_valid(tx_push),
    .in_ready(),
    .out_data(f_data),
    .out_valid(f_valid),
    .out_ready(f_ready)
  );

  // Shifter stalls the FIFO while busy; a write to a full FIFO is dropped
  assign f_ready = !tx_busy_q;
  assign tx_tick = !baud_q;

  // 8N1 shifter, one bit per 16 baud ticks, idle high
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      tx_busy_q <= 1'b0;
      tx_sh_q <= 10'h3FF;
      tx_bits_q <= 4'h0;
      tx_tick_q <= 4'h0;
    end
    else if (clk_en)
    begin
      if (!tx_busy_q && f_valid)
      begin
        tx_busy_q <= 1'b1;
        tx_sh_q <= {1'b1, f_data, 1'b0};
        tx_bits_q <= 4'h0;
        tx_tick_q <= 4'h0;
      end
      else if (tx_busy_q && tx_tick)
      begin
        tx_tick_q <= tx_tick_q + 4'h1;
        if (tx_tick_q == 4'hF)
        begin
          tx_sh_q <= {1'b1, tx_sh_q[9:1]};
          tx_bits_q <= tx_bits_q + 4'h1;
          if (tx_bits_q == 4'h9)
            tx_busy_q <= 1'b0;
        end
      end
    end
  end
  assign tx_serial = tx_sh_q[0];

  // ----------------------------------------------------------------
  // Receive path, timed by the 16x receive clock input
  // ----------------------------------------------------------------
  logic rck_s1_q;
  logic rck_s2_q;
  logic rck_old_q;
  logic rxd_s1_q;
  logic rxd_s2_q;
  logic rx_tick;
  logic rx_busy_q;
  logic [3:0] rx_tc_q;
  logic [3:0] rx_bc_q;
  logic [7:0] rx_sh_q;
  logic rhr_rd;

  // Synchronise clock input and data; reset holds the receiver idle
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      rck_s1_q <= 1'b1; // Idle high like the baud pin, so no false tick
      rck_s2_q <= 1'b1;
      rck_old_q <= 1'b1;
      rxd_s1_q <= 1'b1;
      rxd_s2_q <= 1'b1;
    end
    else if (clk_en)
    begin
      rck_s1_q <= rx_clk_16x;
      rck_s2_q <= rck_s1_q;
      rck_old_q <= rck_s2_q;
      rxd_s1_q <= rx_serial;
      rxd_s2_q <= rxd_s1_q;
    end
  end
  assign rx_tick = rck_s2_q && !rck_old_q;
  assign rhr_rd = rd_act && !div_acc && acc_addr.reg_sel == HUP_OFS_DATA;

  // Mid-bit sampling at tick 8 of each 16
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      rx_busy_q <= 1'b0;
      rx_tc_q <= 4'h0;
      rx_bc_q <= 4'h0;
      rx_sh_q <= 8'h00;
      rx_hold_q <= 8'h00;
      rx_avail_q <= 1'b0;
      overrun_q <= 1'b0;
    end
    else if (clk_en)
    begin
      if (rhr_rd)
        rx_avail_q <= 1'b0;
      if (rx_tick)
      begin
        if (!rx_busy_q)
        begin
          if (!rxd_s2_q)
          begin
            rx_busy_q <= 1'b1;
            rx_tc_q <= 4'h1;
            rx_bc_q <= 4'h0;
          end
        end
        else
        begin
          rx_tc_q <= rx_tc_q + 4'h1;
          if (rx_tc_q == 4'h7)
          begin
            rx_bc_q <= rx_bc_q + 4'h1;
            if (rx_bc_q == 4'h0 && rxd_s2_q)
              rx_busy_q <= 1'b0;
            else if (rx_bc_q == 4'h9)
            begin
              rx_busy_q <= 1'b0;
              rx_hold_q <= rx_sh_q;
              rx_avail_q <= 1'b1; // Set wins over clearing read
              if (rx_avail_q && !rhr_rd)
                overrun_q <= 1'b1;
            end
            else
              rx_sh_q <= {rxd_s2_q, rx_sh_q[7:1]};
          end
        end
      end
      if (rd_act && acc_addr.reg_sel == HUP_OFS_LSTAT && !(rx_tick && rx_bc_q == 4'h9))
        overrun_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt and read mux
  // ----------------------------------------------------------------
  logic tx_empty;
  logic [7:0] lsr_val;
  logic [7:0] isr_val;
  assign tx_empty = !f_valid && !tx_busy_q;
  assign lsr_val = {2'h0, tx_empty, 3'h0, overrun_q, rx_avail_q};

  assign irq = (ien_q[HUP_IE_RX_ERR] && overrun_q)
            || (ien_q[HUP_IE_RX_AVAIL] && rx_avail_q)
            || (ien_q[HUP_IE_TX_EMPTY] && tx_empty)
            || (ien_q[HUP_IE_MODEM] && msr_delta_q);
  assign isr_val = {7'h00, !irq};

  // Data registered so the bus shows a flop output one cycle into a read
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      data_out <= HUP_RST_BYTE;
    else if (clk_en && rd_act)
    begin
      if (div_acc && acc_addr.reg_sel == HUP_OFS_DIV_LO)
        data_out <= div_q[7:0];
      else if (div_acc && acc_addr.reg_sel == HUP_OFS_DIV_HI)
        data_out <= div_q[15:8];
      else if (acc_addr.reg_sel == HUP_OFS_DATA)
        data_out <= rx_hold_q;
      else if (acc_addr.reg_sel == HUP_OFS_IEN)
        data_out <= ien_q;
      else if (acc_addr.reg_sel == HUP_OFS_ISTAT)
        data_out <= isr_val;
      else if (acc_addr.reg_sel == HUP_OFS_LCTL)
        data_out <= lctl_q;
      else if (acc_addr.reg_sel == HUP_OFS_MCTL)
        data_out <= mctl_q;
      else if (acc_addr.reg_sel == HUP_OFS_LSTAT)
        data_out <= lsr_val;
      else if (acc_addr.reg_sel == HUP_OFS_MSTAT)
        data_out <= msr_val;
      else
        data_out <= scratch_q;
    end
  end

endmodule : hup_core

// ==== hup_pkg.sv ====
// Purpose: Shared constants and types for the host-pin and modem-line block
// Assumes: One 20 MHz clock, synchronous active-high reset
// Notes:   Register offsets follow the 3-bit register select field
package hup_pkg;

  // ----------------------------------------------------------------
  // Register select offsets
  // ----------------------------------------------------------------
  localparam logic [2:0] HUP_OFS_DATA = 3'h0;
  localparam logic [2:0] HUP_OFS_IEN = 3'h1;
  localparam logic [2:0] HUP_OFS_ISTAT = 3'h2;
  localparam logic [2:0] HUP_OFS_LCTL = 3'h3;
  localparam logic [2:0] HUP_OFS_MCTL = 3'h4;
  localparam logic [2:0] HUP_OFS_LSTAT = 3'h5;
  localparam logic [2:0] HUP_OFS_MSTAT = 3'h6;
  localparam logic [2:0] HUP_OFS_SCRATCH = 3'h7;
  localparam logic [2:0] HUP_OFS_DIV_LO = 3'h0;
  localparam logic [2:0] HUP_OFS_DIV_HI = 3'h1;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int HUP_MC_TERM_RDY = 0;
  localparam int HUP_MC_REQ_SEND = 1;
  localparam int HUP_MC_USER_ONE = 2;
  localparam int HUP_MC_USER_TWO = 3;
  localparam int HUP_LC_DIV_ACCESS = 7;
  localparam int HUP_IE_RX_AVAIL = 0;
  localparam int HUP_IE_TX_EMPTY = 1;
  localparam int HUP_IE_RX_ERR = 2;
  localparam int HUP_IE_MODEM = 3;
  localparam int HUP_MS_CTS = 4;
  localparam int HUP_LS_RX_AVAIL = 0;
  localparam int HUP_LS_OVERRUN = 1;
  localparam int HUP_LS_TX_EMPTY = 5;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] HUP_RST_BYTE = 8'h00;
  localparam logic [15:0] HUP_RST_DIV = 16'h0001;
  localparam logic [3:0] HUP_RST_MODEM_IN = 4'hF;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  // Latched access select: chip selects plus register select
  typedef struct packed {
    logic sel_a;
    logic sel_b;
    logic sel_c_n;
    logic [2:0] reg_sel;
  } hup_addr_t;

  // Modem inputs, active low as on the pins
  typedef struct packed {
    logic carrier_detect_n;
    logic ring_n;
    logic dsr_n;
    logic cts_n;
  } hup_modem_in_t;

endpackage : hup_pkg

// ==== hup_fifo.sv ====
// Purpose: Flip-flop FIFO with valid/ready on both sides
// Assumes: Synchronous active-high reset, clock enable freezes state
// Notes:   Depth must be a power of two
`timescale 1ns/1ps
module hup_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  import hup_pkg::*;
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  // Honest full and empty from the fill count
  assign in_ready = (cnt_q != (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Storage write
  always_ff @(posedge clk)
  begin
    if (clk_en && push)
      mem_q[wr_q] <= in_data;
  end

  // Pointers and count
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end
    else if (clk_en)
    begin
      if (push)
        wr_q <= wr_q + 1'b1;
      if (pop)
        rd_q <= rd_q + 1'b1;
      if (push && !pop)
        cnt_q <= cnt_q + 1'b1;
      else if (pop && !push)
        cnt_q <= cnt_q - 1'b1;
    end
  end

endmodule : hup_fifo

// ==== hup_core_props.sv ====
// Purpose: Port-level checks on the host pin and modem line block
// Assumes: One clock, synchronous active-high reset
// Notes: Sees only the top module ports
`timescale 1ns/1ps
module hup_core_props (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic select_in_a,
  input wire logic select_in_b,
  input wire logic select_in_c_n,
  input wire logic addr_latch_strobe_n,
  input wire logic read_strobe_low,
  input wire logic write_strobe_low,
  input wire logic [7:0] data_out,
  input wire logic data_oe_n,
  input wire logic irq,
  input wire logic selected_indicator,
  input wire logic bus_drive_disable_n,
  input wire logic tx_serial,
  input wire logic user_output_one_n,
  input wire logic user_output_two_n,
  input wire logic term_ready_n,
  input wire logic req_send_n
);
  // ----------------------------------------------------------------
  // Clocking and sequences
  // ----------------------------------------------------------------
  default clocking @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // Outputs at their reset levels, with an idle serial line from that same cycle
  sequence out_idle_s;
    !irq && term_ready_n && req_send_n && user_output_one_n && user_output_two_n;
  endsequence
  sequence line_idle_s;
    tx_serial [*4];
  endsequence
  sequence start_hold_s;
    !tx_serial [*8];
  endsequence

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  // Latch follows as soon as the strobe is high; checked from the second high sample
  sel_ind_a: assert property (addr_latch_strobe_n && $past(addr_latch_strobe_n)
    && $stable(select_in_a) && $stable(select_in_b) && $stable(select_in_c_n)
    |-> selected_indicator == (select_in_a && select_in_b && !select_in_c_n))
    else $error("select indicator wrong");
  drive_dis_a: assert property (addr_latch_strobe_n |-> bus_drive_disable_n ==
    !(select_in_a && select_in_b && !select_in_c_n && !read_strobe_low))
    else $error("drive disable wrong");
  oe_match_a: assert property (data_oe_n == bus_drive_disable_n)
    else $error("bus enable differs from drive disable");
  rst_out_a: assert property ($fell(sys_rst) |-> out_idle_s ##0 line_idle_s)
    else $error("outputs not at reset level");
  mctl_hold_a: assert property (!$stable({term_ready_n, req_send_n})
    |-> $past(!write_strobe_low && selected_indicator)) else $error("modem out moved");
  user_hold_a: assert property (!$stable({user_output_one_n, user_output_two_n})
    |-> $past(!write_strobe_low && selected_indicator)) else $error("user out moved");
  rdata_hold_a: assert property (!$stable(data_out)
    |-> $past(!read_strobe_low && selected_indicator))
    else $error("read data moved without read");
  start_bit_a: assert property ($fell(tx_serial) |-> start_hold_s)
    else $error("start bit too short");
endmodule : hup_core_props

bind hup_core hup_core_props u_props (.clk(clk), .sys_rst(sys_rst),
  .select_in_a(select_in_a), .select_in_b(select_in_b), .select_in_c_n(select_in_c_n),
  .addr_latch_strobe_n(addr_latch_strobe_n), .read_strobe_low(read_strobe_low),
  .write_strobe_low(write_strobe_low), .data_out(data_out), .data_oe_n(data_oe_n),
  .irq(irq), .selected_indicator(selected_indicator),
  .bus_drive_disable_n(bus_drive_disable_n), .tx_serial(tx_serial),
  .user_output_one_n(user_output_one_n), .user_output_two_n(user_output_two_n),
  .term_ready_n(term_ready_n), .req_send_n(req_send_n));

// ==== hup_modem_model.sv ====
// Purpose: Data set on the serial and handshake side
// Assumes: Remote echo of every transmitted bit
// Notes: Handshake levels come from the bench
`timescale 1ns/1ps
module hup_modem_model (
  input wire logic tx_serial,
  input wire logic baud_out_n,
  input wire hup_pkg::hup_modem_in_t lines,
  output logic rx_serial,
  output logic rx_clk_16x,
  output hup_pkg::hup_modem_in_t modem_in
);
  import hup_pkg::*;
  // Board strap: receiver runs at the transmitter rate
  assign rx_clk_16x = baud_out_n;
  // Echo keeps the receiver busy without a second stimulus source
  assign rx_serial = tx_serial;
  assign modem_in = lines;
endmodule : hup_modem_model

// ==== hup_core_tb.sv ====
// Purpose: Self-checking bench for the host pin and modem line block
// Assumes: Inputs change on the falling edge
// Notes: Divisor 2 keeps one character near 320 cycles
`timescale 1ns/1ps
module hup_core_tb;
  import hup_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic ce = 1'b1;
  logic sa = 1'b1;
  logic sb = 1'b1;
  logic sc_n = 1'b0;
  logic [2:0] rs = 3'h0;
  logic als_n = 1'b1;
  logic rd_n = 1'b1;
  logic wr_n = 1'b1;
  logic [7:0] din = 8'h00;
  logic [7:0] dout;
  logic oe_n, irq, sel_ind, dd_n, baud_n, rxc, rxd, txd;
  logic op1_n, op2_n, tr_n, rq_n;
  hup_modem_in_t md = 4'hF;
  hup_modem_in_t mdi;
  logic [7:0] v;
  int err_total = 0;
  int total_checks = 0;
  int n;

  // ----------------------------------------------------------------
  // Clock, design and far side
  // ----------------------------------------------------------------
  initial forever #25 clk = ~clk;
  hup_core u_dut (.clk(clk), .sys_rst(sys_rst), .clk_en(ce), .select_in_a(sa),
    .select_in_b(sb), .select_in_c_n(sc_n), .reg_sel(rs), .addr_latch_strobe_n(als_n),
    .read_strobe_low(rd_n), .write_strobe_low(wr_n), .data_in(din), .data_out(dout),
    .data_oe_n(oe_n), .irq(irq), .selected_indicator(sel_ind),
    .bus_drive_disable_n(dd_n), .baud_out_n(baud_n), .rx_clk_16x(rxc), .rx_serial(rxd),
    .tx_serial(txd), .user_output_one_n(op1_n), .user_output_two_n(op2_n),
    .term_ready_n(tr_n), .req_send_n(rq_n), .modem_in(mdi));
  hup_modem_model u_modem (.tx_serial(txd), .baud_out_n(baud_n), .lines(md),
    .rx_serial(rxd), .rx_clk_16x(rxc), .modem_in(mdi));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    total_checks++;
    if (s !== e)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  // Strobe high for a cycle afterwards so each write lands once
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge clk);
    rs = a;
    din = d;
    wr_n = 1'b0;
    @(negedge clk);
    wr_n = 1'b1;
    @(negedge clk);
  endtask : wr

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(negedge clk);
    rs = a;
    rd_n = 1'b0;
    @(negedge clk);
    chk("bus_drive_disable_n", {7'h0, dd_n}, 8'h00);
    chk("oe", {7'h0, oe_n}, 8'h00);
    d = dout;
    rd_n = 1'b1;
  endtask : rd

  task automatic rdc(input logic [2:0] a, input logic [7:0] e);
    logic [7:0] t;
    rd(a, t);
    chk("rdata", t, e);
  endtask : rdc

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : report_and_stop

  // Hang guard
  initial
  begin
    repeat (20000) @(posedge clk);
    err_total++;
    report_and_stop();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (6) @(negedge clk);
    chk("rst", {2'h0, tr_n, rq_n, op1_n, op2_n, txd, irq}, 8'h3E);
    sys_rst = 1'b0;
    wr(3'h7, 8'hA5);
    rdc(3'h7, 8'hA5);
    // Each select failing alone, with a read and a write attempt
    for (int i = 0; i < 3; i++)
    begin
      sa = (i != 0);
      sb = (i != 1);
      sc_n = (i == 2);
      rd_n = 1'b0;
      @(negedge clk);
      chk("unsel_ind", {7'h0, sel_ind}, 8'h00);
      chk("unsel_oe", {7'h0, oe_n}, 8'h01);
      rd_n = 1'b1;
      wr(3'h7, 8'h3C);
      sa = 1'b1;
      sb = 1'b1;
      sc_n = 1'b0;
      @(negedge clk);
      chk("sel_ind", {7'h0, sel_ind}, 8'h01);
      rdc(3'h7, 8'hA5);
    end
    for (int i = 0; i < 4; i++)
    begin
      wr(3'h4, 8'h01 << i);
      chk("mout", {4'h0, tr_n, rq_n, op1_n, op2_n}, {4'h0, ~(4'h8 >> i)});
    end
    wr(3'h4, 8'h00);
    // Latch scratch select, then present the modem control offset
    rs = 3'h7;
    @(negedge clk);
    als_n = 1'b0;
    wr(3'h4, 8'h5C);
    chk("latch_mout", {4'h0, tr_n, rq_n, op1_n, op2_n}, 8'h0F);
    als_n = 1'b1;
    rdc(3'h7, 8'h5C);
    // Enable low freezes all state, so a write in that window is lost
    ce = 1'b0;
    wr(3'h7, 8'h11);
    ce = 1'b1;
    rdc(3'h7, 8'h5C);
    md = 4'b0110;
    repeat (4) @(negedge clk);
    rd(3'h6, v);
    chk("mstat_cts", v & 8'hB0, 8'h90);
    md = 4'b1101;
    repeat (4) @(negedge clk);
    rd(3'h6, v);
    chk("mstat_dsr", v & 8'hB0, 8'h20);
    wr(3'h3, 8'h80);
    wr(3'h0, 8'h02);
    wr(3'h1, 8'h00);
    rdc(3'h0, 8'h02);
    wr(3'h3, 8'h03);
    rdc(3'h3, 8'h03);
    n = 0;
    repeat (40) @(negedge clk) n += !baud_n;
    chk("baud", n[7:0], 8'h14);
    wr(3'h1, 8'h02);
    chk("irq_tx", {7'h0, irq}, 8'h01);
    wr(3'h1, 8'h00);
    chk("irq_off", {7'h0, irq}, 8'h00);
    // Clear-to-send is deasserted: the character must still go out and return
    wr(3'h0, 8'h5A);
    v = 8'h00;
    for (int k = 0; k < 600 && !v[0]; k++)
      rd(3'h5, v);
    // A character that never returns counts as a mismatch
    if (!v[0])
      err_total++;
    else
    begin
      wr(3'h1, 8'h01);
      chk("irq_rx", {7'h0, irq}, 8'h01);
      rdc(3'h0, 8'h5A);
      chk("irq_clr", {7'h0, irq}, 8'h00);
    end
    report_and_stop();
  end
endmodule : hup_core_tb
